/* core/dcct_timer.sv */
// Dual channel 16-bit capture/compare timer with a CPU register port.
// Assumes pins and the bus are synchronous to clk; external pulses last two cycles.
//
// Overview of operation
// - Upper five bits of each level control register read 1, ignore writes.
// - Level bits D, C, B at positions 2..0, reset 0, choose active level.
// - Each channel owns its own level control register.
// - Counters and general registers are accessed as whole 16-bit words only.
// - All other registers are 8 bits wide on an 8-bit path.
// - Setting a channel run bit starts its counter.
// - After reset both counters are free-running up counters.
// - Overflow sets the overflow flag, counting continues from zero.
// - Overflow flag with its enable set raises the overflow request.
// - Compare clearing: equality sets the match flag and clears the counter.
// - Match or capture flag with its enable set raises its request.
// - Count clock is system clock or divided by 2, 4 or 8.
// - External clock pin counts on rising, falling or both edges.
// - Compare match drives its pin to 0, 1 or toggles it.
// - Commanding the pin's present level leaves it unchanged.
// - Match acts only when the counter leaves the matching value.
// - Selected pin edge copies the counter into a capture register.
// - An input capture may clear the channel counter.
// - A flag clears by reading it as 1, then writing 0.
// - A capture into a general register sets its match flag.
// - PWM: duty match drives the level bit, period match A its inverse.
`timescale 1ns/100ps
`include "dcct_consts.svh"

module dcct_timer #(
  parameter int NCH = 2                            // Channel count
) (
  input  wire logic                     clk,       // System clock
  input  wire logic                     rst_n,     // Synchronous reset, low
  input  wire logic [5:0]               bus_addr,  // Register address
  input  wire logic                     bus_wr,    // Write strobe
  input  wire logic                     bus_rd,    // Read strobe
  input  wire logic                     bus_word,  // 1: 16-bit, 0: 8-bit access
  input  wire logic [15:0]              bus_wdata, // Write data
  output logic [15:0]                   bus_rdata, // Read data, next cycle
  input  wire logic [NCH-1:0]           ext_count_clock_pin,    // External clocks
  input  wire logic [NCH-1:0][3:0]      capture_compare_pin_in, // Pin levels D..A
  output dcct_pkg::dcct_pins_t [NCH-1:0] capture_compare_pin,   // Pin drive
  output dcct_pkg::dcct_irq_t  [NCH-1:0] irq                    // Requests
);

  // ========================================================================
  // Helpers
  // Edge hit for a select code: rising, falling or both
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic [1:0] sel);
    logic r;
    r = 1'b0;
    case (sel)
      `DCCT_EDGE_RISE: r = ~prev & cur;
      `DCCT_EDGE_FALL: r = prev & ~cur;
      default:         r = prev ^ cur;
    endcase
    return r;
  endfunction

  // Count enable for the prescaler code
  function automatic logic psc_tick(input logic [2:0] sel, input logic [2:0] div,
                                    input logic ext);
    logic r;
    r = 1'b0;
    if (sel[`DCCT_PSC_EXT]) begin
      r = ext;
    end else begin
      case (sel[1:0])
        2'h0:    r = 1'b1;
        2'h1:    r = div[0];
        2'h2:    r = &div[1:0];
        default: r = &div;
      endcase
    end
    return r;
  endfunction

  // ========================================================================
  // Shared registers
  logic [NCH-1:0] run_q;       // Run bits
  logic [NCH-1:0] pwm_q;       // PWM mode bits
  logic [2:0]     div_q;       // Free prescaler
  logic           wr8_glb;
  logic [15:0]    rd_ch [NCH];

  assign wr8_glb = bus_wr & ~bus_word;

  // Prescaler divider, always running
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // Start and mode registers, byte wide
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q <= '0;
      pwm_q <= '0;
    end else if (wr8_glb && bus_addr == `DCCT_ADR_START) begin
      run_q <= bus_wdata[NCH-1:0];
    end else if (wr8_glb && bus_addr == `DCCT_ADR_MODE) begin
      pwm_q <= bus_wdata[NCH-1:0];
    end
  end

  // ========================================================================
  // Channels
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic [15:0]         count_q;
    logic [15:0]         general_reg_q [4];
    dcct_pkg::dcct_ctrl_t ctrl_q;
    logic [3:0][2:0]     io_q;
    logic [4:0]          ien_q;
    logic [4:0]          flag_q;
    logic [4:0]          armed_q;
    logic [2:0]          level_q;
    logic [3:0]          out_q;
    logic [3:0]          pin_prev_q;
    logic                ext_prev_q;
    logic                sel;
    logic                wr8;
    logic                wr16;
    logic [3:0]          ofs;
    logic                tick;
    logic                clr;
    logic                wrap_ev;
    logic [3:0]          lvl4;
    logic [3:0]          cmp;
    logic [3:0]          cap;
    logic [3:0]          oe;
    logic [15:0]         rd_v;

    assign sel  = bus_addr[5:4] == 2'(ch);
    assign ofs  = bus_addr[3:0];
    assign wr8  = bus_wr & sel & ~bus_word;
    assign wr16 = bus_wr & sel & bus_word;

    // Count enable from the selected source
    assign tick = run_q[ch] & psc_tick(ctrl_q.prescale_sel, div_q,
                  edge_hit(ext_prev_q, ext_count_clock_pin[ch], ctrl_q.edge_sel));

    // Match and capture events per general register
    always_comb begin
      for (int i = 0; i < 4; i++) begin
        cmp[i] = tick & ~io_q[i][`DCCT_IO_CAP] & (count_q == general_reg_q[i]);
        cap[i] = io_q[i][`DCCT_IO_CAP] &
                 edge_hit(pin_prev_q[i], capture_compare_pin_in[ch][i],
                          io_q[i][1:0]);
        oe[i]  = ~io_q[i][`DCCT_IO_CAP] &
                 ((io_q[i][1:0] != 2'h0) | (pwm_q[ch] & (i != 0)));
      end
    end

    // Clearing source and overflow detection
    assign clr = (ctrl_q.clear_sel == `DCCT_CLR_GEN_A & (cmp[0] | cap[0])) |
                 (ctrl_q.clear_sel == `DCCT_CLR_GEN_B & (cmp[1] | cap[1]));
    assign wrap_ev = tick & (&count_q) & ~clr;

    // PWM levels lined up with pins D..A, pin A has none
    assign lvl4 = {level_q, 1'b0};

    // Sampled pins for edge detection
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pin_prev_q <= 4'h0;
        ext_prev_q <= 1'b0;
      end else begin
        pin_prev_q <= capture_compare_pin_in[ch];
        ext_prev_q <= ext_count_clock_pin[ch];
      end
    end

    // Counter: CPU write, then clear, then increment
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        count_q <= `DCCT_RST_COUNT;
      end else if (wr16 && ofs == `DCCT_OFS_COUNT) begin
        count_q <= bus_wdata;
      end else if (clr) begin
        count_q <= `DCCT_RST_COUNT;
      end else if (tick) begin
        count_q <= count_q + 16'h0001;
      end
    end

    // General registers: capture has priority over a CPU write
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        for (int i = 0; i < 4; i++) begin
          general_reg_q[i] <= `DCCT_RST_GEN;
        end
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (cap[i]) begin
            general_reg_q[i] <= count_q;
          end else if (wr16 && ofs == `DCCT_OFS_GEN_A + 4'(2 * i)) begin
            general_reg_q[i] <= bus_wdata;
          end
        end
      end
    end

    // Byte control registers
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ctrl_q  <= '0;
        io_q    <= '0;
        ien_q   <= 5'h00;
        level_q <= 3'h0;
      end else if (wr8) begin
        case (ofs)
          `DCCT_OFS_CTRL:  ctrl_q <= bus_wdata[6:0];
          `DCCT_OFS_IO_AB: io_q[1:0] <= {bus_wdata[6:4], bus_wdata[2:0]};
          `DCCT_OFS_IO_CD: io_q[3:2] <= {bus_wdata[6:4], bus_wdata[2:0]};
          `DCCT_OFS_IRQEN: ien_q <= bus_wdata[4:0];
          `DCCT_OFS_LEVEL: level_q <= bus_wdata[2:0];
          default:         level_q <= level_q;
        endcase
      end
    end

    // Flags: hardware set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        flag_q  <= 5'h00;
        armed_q <= 5'h00;
      end else if (wr8 && ofs == `DCCT_OFS_STATUS) begin
        flag_q  <= (flag_q & ~(armed_q & ~bus_wdata[4:0])) |
                   {wrap_ev, cmp | cap};
        armed_q <= 5'h00;
      end else begin
        flag_q  <= flag_q | {wrap_ev, cmp | cap};
        if (bus_rd && sel && !bus_word && ofs == `DCCT_OFS_STATUS) begin
          armed_q <= armed_q | flag_q;
        end
      end
    end

    // Pin levels on compare match
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        out_q <= 4'h0;
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (pwm_q[ch] && i != 0) begin
            if (cmp[0]) begin
              out_q[i] <= ~lvl4[i];
            end else if (cmp[i]) begin
              out_q[i] <= lvl4[i];
            end
          end else if (cmp[i]) begin
            case (io_q[i][1:0])
              `DCCT_OUT_0:   out_q[i] <= 1'b0;
              `DCCT_OUT_1:   out_q[i] <= 1'b1;
              `DCCT_OUT_TGL: out_q[i] <= ~out_q[i];
              default:       out_q[i] <= out_q[i];
            endcase
          end
        end
      end
    end

    // Read multiplexer with width check
    always_comb begin
      rd_v = 16'h0000;
      if (bus_word) begin
        if (ofs == `DCCT_OFS_COUNT) begin
          rd_v = count_q;
        end
        for (int i = 0; i < 4; i++) begin
          if (ofs == `DCCT_OFS_GEN_A + 4'(2 * i)) begin
            rd_v = general_reg_q[i];
          end
        end
      end else begin
        case (ofs)
          `DCCT_OFS_CTRL:   rd_v = {9'h000, ctrl_q};
          `DCCT_OFS_IO_AB:  rd_v = {9'h000, io_q[1], 1'b0, io_q[0]};
          `DCCT_OFS_IO_CD:  rd_v = {9'h000, io_q[3], 1'b0, io_q[2]};
          `DCCT_OFS_IRQEN:  rd_v = {8'h00, `DCCT_RSV_FLAGS, ien_q};
          `DCCT_OFS_STATUS: rd_v = {8'h00, `DCCT_RSV_FLAGS, flag_q};
          `DCCT_OFS_LEVEL:  rd_v = {8'h00, `DCCT_RSV_LEVEL, level_q};
          default:          rd_v = 16'h0000;
        endcase
      end
    end

    assign rd_ch[ch] = sel ? rd_v : 16'h0000;
    assign capture_compare_pin[ch].drive = out_q;
    assign capture_compare_pin[ch].oe    = oe;
    // Requests gated by their enables
    assign irq[ch].overflow = flag_q[4] & ien_q[4];
    assign irq[ch].match = flag_q[3:0] & ien_q[3:0];
  end

  // ========================================================================
  // Registered read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      if (!bus_word && bus_addr == `DCCT_ADR_START) begin
        bus_rdata <= {8'h00, 6'h00, run_q};
      end else if (!bus_word && bus_addr == `DCCT_ADR_MODE) begin
        bus_rdata <= {8'h00, 6'h00, pwm_q};
      end else begin
        bus_rdata <= rd_ch[0] | rd_ch[1];
      end
    end
  end

endmodule

/* core/dcct_consts.svh */
// Constants of the dual channel capture/compare timer: offsets, fields, resets.
// Assumes inclusion by bare name from the timer core.
`ifndef DCCT_CONSTS_SVH
`define DCCT_CONSTS_SVH

// ==========================================================================
// Register offsets inside one channel window (address bits 3:0)
`define DCCT_OFS_COUNT   4'h0
`define DCCT_OFS_GEN_A   4'h2
`define DCCT_OFS_CTRL    4'hA
`define DCCT_OFS_IO_AB   4'hB
`define DCCT_OFS_IO_CD   4'hC
`define DCCT_OFS_IRQEN   4'hD
`define DCCT_OFS_STATUS  4'hE
`define DCCT_OFS_LEVEL   4'hF

// ==========================================================================
// Shared byte registers
`define DCCT_ADR_START   6'h20
`define DCCT_ADR_MODE    6'h21

// ==========================================================================
// Reset values and reserved read-back
`define DCCT_RST_COUNT   16'h0000
`define DCCT_RST_GEN     16'hFFFF
`define DCCT_RSV_FLAGS   3'h7
`define DCCT_RSV_LEVEL   5'h1F

// ==========================================================================
// Field codes
`define DCCT_CLR_GEN_A   2'h1
`define DCCT_CLR_GEN_B   2'h2
`define DCCT_PSC_EXT     2
`define DCCT_IO_CAP      2
`define DCCT_OUT_0       2'h1
`define DCCT_OUT_1       2'h2
`define DCCT_OUT_TGL     2'h3
`define DCCT_EDGE_RISE   2'h0
`define DCCT_EDGE_FALL   2'h1

`endif

/* core/dcct_pkg.sv */
// Types of the dual channel capture/compare timer.
// Assumes nothing beyond a SystemVerilog compiler.
package dcct_pkg;

  // ========================================================================
  // Channel control byte
  typedef struct packed {
    logic [1:0] clear_sel;     // Counter clearing source
    logic [1:0] edge_sel;      // External clock edge
    logic [2:0] prescale_sel;  // Count clock source
  } dcct_ctrl_t;

  // ========================================================================
  // Pin drive of one channel
  typedef struct packed {
    logic [3:0] drive;         // Output level, pins D..A
    logic [3:0] oe;            // Output enable, pins D..A
  } dcct_pins_t;

  // ========================================================================
  // Interrupt requests of one channel
  typedef struct packed {
    logic       overflow;      // Overflow request
    logic [3:0] match;         // Match/capture requests D..A
  } dcct_irq_t;

endpackage

/* bench/dcct_timer_properties.sv */
// Concurrent checks on the register port and outputs of the timer.
// Assumes binding to dcct_timer; one clock, synchronous low reset.
`timescale 1ns/100ps

module dcct_timer_properties #(
  parameter int NCH = 2                                    // Channel count
) (
  input wire logic                           clk,                 // System clock
  input wire logic                           rst_n,               // Reset, low
  input wire logic [5:0]                     bus_addr,            // Address
  input wire logic                           bus_wr,              // Write strobe
  input wire logic                           bus_rd,              // Read strobe
  input wire logic                           bus_word,            // Word access
  input wire logic [15:0]                    bus_wdata,           // Write data
  input wire logic [15:0]                    bus_rdata,           // Read data
  input wire dcct_pkg::dcct_pins_t [NCH-1:0] capture_compare_pin, // Pin drive
  input wire dcct_pkg::dcct_irq_t  [NCH-1:0] irq                  // Requests
);
  // ==========================================================================
  // Register port and output checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  rdata_hold_a: assert property (!$stable(bus_rdata) |-> $past(bus_rd))
    else $error("read data moved without a read");
  level_rsv_a: assert property (
    bus_rd && !bus_word && !bus_addr[5] && bus_addr[3:0] == 4'hF
    |=> bus_rdata[15:3] == 13'h001F) else $error("level reserved bits wrong");
  level_rdbk_a: assert property (
    bus_wr && !bus_word && !bus_addr[5] && bus_addr[3:0] == 4'hF
    ##1 bus_rd && !bus_wr && !bus_word && bus_addr == $past(bus_addr)
    |=> bus_rdata[2:0] == $past(bus_wdata[2:0], 2)) else $error("level bits lost");
  byte_refuse_a: assert property (
    bus_rd && !bus_word && !bus_addr[5] && bus_addr[3:0] == 4'h0
    |=> bus_rdata == 16'h0000) else $error("byte read of counter answered");
  word_refuse_a: assert property (
    bus_rd && bus_word && !bus_addr[5] && bus_addr[3:0] == 4'hF
    |=> bus_rdata == 16'h0000) else $error("word read of byte register answered");
  reset_quiet_a: assert property (
    $rose(rst_n) |-> irq == '0 && bus_rdata == 16'h0000) else $error("not quiet after reset");
  irq_fall_a: assert property (|($past(irq) & ~irq) |-> $past(bus_wr))
    else $error("request dropped without a write");
  oe_write_a: assert property (
    !$stable({capture_compare_pin[1].oe, capture_compare_pin[0].oe}) |-> $past(bus_wr))
    else $error("pin enable moved without a write");
endmodule

/* bench/dcct_cpu_model.sv */
// CPU side of the timer's register port: byte and word accesses, one per clock.
// Assumes the bench pops exp_q when read data appears.
`timescale 1ns/100ps

module dcct_cpu_model (
  input  wire logic  clk,       // System clock
  output logic [5:0] bus_addr,  // Address
  output logic       bus_wr,    // Write strobe
  output logic       bus_rd,    // Read strobe
  output logic       bus_word,  // Word access
  output logic [15:0] bus_wdata // Write data
);
  logic [15:0] exp_q[$];  // Expected read data, oldest first

  // ==========================================================================
  // Bus cycles
  // Idle bus at time zero
  initial begin
    {bus_wr, bus_rd, bus_word, bus_addr, bus_wdata} = '0;
  end

  // Present one access after an edge; held until the next call
  task automatic op(input logic wr, input logic wd, input logic [5:0] adr,
                    input logic [15:0] d);
    @(posedge clk);
    bus_wr    <= wr;
    bus_rd    <= !wr;
    bus_word  <= wd;
    bus_addr  <= adr;
    bus_wdata <= d;
  endtask

  // Note the expected data, then read
  task automatic rd(input logic wd, input logic [5:0] adr, input logic [15:0] e);
    exp_q.push_back(e);
    op(1'b0, wd, adr, 16'h0000);
  endtask

  // Release the bus; data lines no longer show the last value
  task automatic idle();
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_rd    <= 1'b0;
    bus_wdata <= ~bus_wdata;
  endtask
endmodule

/* bench/dcct_timer_tb.sv */
// Self-checking bench of the dual channel timer driven by a CPU model.
// Assumes package, core, checker and CPU model compiled before it.
`timescale 1ns/100ps

module dcct_timer_tb;
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [5:0]                 bus_addr;
  logic                       bus_wr;
  logic                       bus_rd;
  logic                       bus_word;
  logic [15:0]                bus_wdata;
  logic [15:0]                bus_rdata;
  logic [1:0]                 ext_count_clock_pin = '0;
  logic [1:0][3:0]            capture_compare_pin_in = '0;
  dcct_pkg::dcct_pins_t [1:0] capture_compare_pin;
  dcct_pkg::dcct_irq_t  [1:0] irq;
  logic                       rd_seen = 1'b0;
  logic [31:0]                rnd = 32'h0001_62C8;
  int                         miscompares = 0;
  int                         check_count = 0;
  int                         cycles = 0;

  dcct_cpu_model i_cpu (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_word(bus_word), .bus_wdata(bus_wdata));
  dcct_timer #(.NCH(2)) i_dut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_word(bus_word), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .ext_count_clock_pin(ext_count_clock_pin),
    .capture_compare_pin_in(capture_compare_pin_in),
    .capture_compare_pin(capture_compare_pin), .irq(irq));

  // ==========================================================================
  // Clock, reset, timeout and read monitor
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rd_seen <= bus_rd;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  always @(negedge clk) begin
    if (rd_seen) chk("rdata", i_cpu.exp_q.pop_front(), bus_rdata);
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] got);
    check_count++;
    if (got !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, got);
    end
  endtask

  // Run the masked channels for exactly n system clock cycles
  task automatic run(input int n, input logic [1:0] ch);
    i_cpu.op(1'b1, 1'b0, 6'h20, {14'h0000, ch});
    i_cpu.idle();
    repeat (n - 2) @(posedge clk);
    i_cpu.op(1'b1, 1'b0, 6'h20, 16'h0000);
    i_cpu.idle();
    @(negedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, level registers per channel
    i_cpu.rd(1'b0, 6'h0F, 16'h00F8);
    i_cpu.rd(1'b0, 6'h1F, 16'h00F8);
    i_cpu.rd(1'b0, 6'h0E, 16'h00E0);
    i_cpu.rd(1'b1, 6'h02, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      i_cpu.op(1'b1, 1'b0, 6'h0F, rnd[15:0]);
      i_cpu.rd(1'b0, 6'h0F, {8'h00, 5'h1F, rnd[2:0]});
      i_cpu.op(1'b1, 1'b0, 6'h1F, ~rnd[15:0]);
      i_cpu.rd(1'b0, 6'h1F, {8'h00, 5'h1F, ~rnd[2:0]});
      i_cpu.rd(1'b0, 6'h0F, {8'h00, 5'h1F, rnd[2:0]});
    end
    // Wrong access widths are refused
    i_cpu.op(1'b1, 1'b1, 6'h0F, 16'h0000);
    i_cpu.rd(1'b1, 6'h0F, 16'h0000);
    i_cpu.rd(1'b0, 6'h0F, {8'h00, 5'h1F, rnd[2:0]});
    i_cpu.op(1'b1, 1'b0, 6'h00, 16'h00FF);
    i_cpu.rd(1'b0, 6'h00, 16'h0000);
    i_cpu.rd(1'b1, 6'h00, 16'h0000);
    // Internal prescaler rates
    for (int p = 0; p < 4; p++) begin
      i_cpu.op(1'b1, 1'b0, 6'h0A, {13'h0000, p[2:0]});
      i_cpu.op(1'b1, 1'b1, 6'h00, 16'h0000);
      run(64, 2'b01);
      i_cpu.rd(1'b1, 6'h00, 16'h0040 >> p);
    end
    // External clock on rising, falling and both edges
    for (int e = 0; e < 3; e++) begin
      i_cpu.op(1'b1, 1'b0, 6'h0A, {11'h000, e[1:0], 3'h4});
      i_cpu.op(1'b1, 1'b1, 6'h00, 16'h0000);
      i_cpu.op(1'b1, 1'b0, 6'h20, 16'h0001);
      i_cpu.idle();
      for (int k = 0; k < 8; k++) begin
        repeat (2) @(posedge clk);
        ext_count_clock_pin[0] <= ~ext_count_clock_pin[0];
      end
      repeat (3) @(posedge clk);
      i_cpu.op(1'b1, 1'b0, 6'h20, 16'h0000);
      i_cpu.rd(1'b1, 6'h00, (e == 2) ? 16'h0008 : 16'h0004);
    end
    // Overflow, request, read-then-write clearing
    i_cpu.op(1'b1, 1'b0, 6'h0A, 16'h0000);
    i_cpu.op(1'b1, 1'b0, 6'h0D, 16'h0010);
    i_cpu.op(1'b1, 1'b1, 6'h00, 16'hFFFE);
    run(4, 2'b01);
    chk("wrap_irq", 16'h0001, {15'h0000, irq[0].overflow});
    i_cpu.rd(1'b1, 6'h00, 16'h0002);
    i_cpu.op(1'b1, 1'b0, 6'h0E, 16'h0000);
    // Compare registers still all ones, so A..D match at the wrap as well
    i_cpu.rd(1'b0, 6'h0E, 16'h00FF);
    i_cpu.op(1'b1, 1'b0, 6'h0E, 16'h0000);
    i_cpu.rd(1'b0, 6'h0E, 16'h00E0);
    // Match A clears the counter, toggles pin A; match B drives 0 onto a low pin B
    i_cpu.op(1'b1, 1'b1, 6'h02, 16'h0003);
    i_cpu.op(1'b1, 1'b1, 6'h04, 16'h0001);
    i_cpu.op(1'b1, 1'b0, 6'h0A, 16'h0020);
    i_cpu.op(1'b1, 1'b0, 6'h0B, 16'h0013);
    i_cpu.op(1'b1, 1'b0, 6'h0D, 16'h0001);
    i_cpu.op(1'b1, 1'b1, 6'h00, 16'h0000);
    run(4, 2'b01);
    chk("pins", 16'h0013, {8'h00, capture_compare_pin[0]});
    chk("irq_a", 16'h0001, {11'h000, irq[0]});
    i_cpu.rd(1'b1, 6'h00, 16'h0000);
    i_cpu.rd(1'b0, 6'h0E, 16'h00E3);
    // PWM on pin B, high active: duty match sets, period match clears
    i_cpu.op(1'b1, 1'b1, 6'h04, 16'h0001);
    i_cpu.op(1'b1, 1'b0, 6'h0F, 16'h0001);
    i_cpu.op(1'b1, 1'b0, 6'h21, 16'h0001);
    i_cpu.op(1'b1, 1'b1, 6'h00, 16'h0000);
    run(2, 2'b01);
    chk("pwm_duty", 16'h0001, {15'h0000, capture_compare_pin[0].drive[1]});
    run(2, 2'b01);
    chk("pwm_period", 16'h0000, {15'h0000, capture_compare_pin[0].drive[1]});
    // Capture on channel 1 pin A while stopped, clearing the counter
    i_cpu.op(1'b1, 1'b0, 6'h1B, 16'h0004);
    i_cpu.op(1'b1, 1'b0, 6'h1A, 16'h0020);
    i_cpu.op(1'b1, 1'b1, 6'h10, 16'h0123);
    i_cpu.idle();
    capture_compare_pin_in[1][0] <= 1'b1;
    repeat (3) @(posedge clk);
    i_cpu.rd(1'b1, 6'h12, 16'h0123);
    i_cpu.rd(1'b0, 6'h1E, 16'h00E1);
    i_cpu.rd(1'b1, 6'h10, 16'h0000);
    i_cpu.idle();
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule

bind dcct_timer dcct_timer_properties #(.NCH(NCH)) i_props (
  .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .capture_compare_pin(capture_compare_pin), .irq(irq));
